// ---- rtl/mbw_consts.svh ----
// constants of the holding-register frame handler
// assumes inclusion by mbw_top.sv only; mbw_pkg.sv does not include it
`ifndef MBW_CONSTS_SVH
`define MBW_CONSTS_SVH

// function codes handled here
`define MBW_FC_WRITE_MULTI   8'h10
`define MBW_FC_READ_WRITE    8'h17
`define MBW_FC_WRITE_SINGLE  8'h06
`define MBW_EXC_FLAG         8'h80
`define MBW_BCAST_ADDR       8'h00

// recalculation command: register number, value and line address
`define MBW_RECALC_REG       16'h0900
`define MBW_RECALC_ADDR      (`MBW_RECALC_REG - 16'h0001)
`define MBW_RECALC_VALUE     16'h0000

// frame limits
`define MBW_MAX_WCNT_10      16'h007B
`define MBW_MAX_RCNT_17      16'h007D
`define MBW_MAX_WCNT_17      16'h0079
`define MBW_MIN_FRAME        9'h004
`define MBW_CRC_INIT         16'hFFFF
`define MBW_CRC_POLY         16'hA001

// apb byte offsets
`define MBW_OFS_CTRL         12'h000
`define MBW_OFS_DRIVE        12'h004
`define MBW_OFS_LOCK         12'h008
`define MBW_OFS_STATUS       12'h00C
`define MBW_OFS_HREG         12'h100

// control field positions and reset values
`define MBW_CTRL_EN_BIT      8
`define MBW_DRV_RUN_BIT      0
`define MBW_DRV_UV_BIT       1
`define MBW_DRV_TRIP_BIT     2
`define MBW_RST_SLAVE_ADDR   8'h01
`define MBW_RST_EN           1'b1

`endif

// ---- rtl/mbw_pkg.sv ----
// types of the holding-register frame handler
// assumes mbw_consts.svh is on the include path
package mbw_pkg;

    // gray steps along idle -> rx -> check -> write -> read -> transmit
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_RX    = 3'h1,
        S_CHECK = 3'h3,
        S_WR    = 3'h2,
        S_RD    = 3'h6,
        S_TX    = 3'h7
    } mbw_state_t;

    typedef enum logic [7:0] {
        EXC_NONE   = 8'h00,
        EXC_FUNC   = 8'h01,
        EXC_ADDR   = 8'h02,
        EXC_DATA   = 8'h03,
        EXC_DRIVE  = 8'h22
    } mbw_exc_t;

endpackage : mbw_pkg

// ---- rtl/mbw_top.sv ----
// holding-register write, read/write and exception frame handler
// assumes a framer outside delivers received bytes and an end-of-frame
// pulse after the line gap, and serialises the transmitted bytes
// Summary of operation
// - 10h writes consecutive holding registers from start
// - line address is register number minus one
// - 10h reply echoes address, start, count, CRC
// - 17h writes then reads register runs
// - 17h reply: byte count, read data, CRC
// - reply to addressed queries, never to broadcast
// - errors answered by exception frame instead
// - exception function code is query plus 80h
// - codes 01h function, 02h address, 03h data
// - recalculation while running or undervoltage gives 22h
// - writes to locked registers while running, and tripped writes, give 22h
`include "mbw_consts.svh"

module mbw_top #(
    parameter int          DEPTH     = 16,
    parameter int          MAXB      = 256,
    parameter logic [15:0] HREG_BASE = 16'h0001
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // received bytes from the framer
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_end,
    // bytes to transmit
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    // drive side
    output logic             recalc_pulse,
    output logic             busy
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [16:0] BASE_LINE = {1'b0, HREG_BASE} - 17'h00001;
    localparam logic [16:0] DEPTH17   = 17'(DEPTH);

    typedef struct packed {
        mbw_pkg::mbw_state_t        st;
        logic [MAXB-1:0][7:0]       buf_b;
        logic [8:0]                 len;
        logic                       ovf;
        logic [15:0]                crc;
        logic [8:0]                 txi;
        logic [7:0]                 txd;
        logic [7:0]                 idx;
        logic [7:0]                 wcnt;
        logic [7:0]                 rcnt;
        logic [AW-1:0]              wbase;
        logic [AW-1:0]              rbase;
        logic [8:0]                 dptr;
        logic                       is17;
        logic                       bcast;
        logic [DEPTH-1:0][15:0]     hreg;
        logic [7:0]                 my_addr;
        logic                       en;
        logic                       run;
        logic                       uv;
        logic                       trip;
        logic [DEPTH-1:0]           lock;
        logic [7:0]                 ok_cnt;
        logic [7:0]                 crc_cnt;
        logic [7:0]                 last_exc;
        logic [31:0]                prdata;
        logic                       recalc;
    } mbw_regs_t;

    mbw_regs_t q, d;

    // one byte of the reflected crc-16
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0]  b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBW_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // line address a with count c inside the bank
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] c);
        logic [16:0] rel;
        rel = {1'b0, a} - BASE_LINE;
        return ({1'b0, a} >= BASE_LINE) && (rel + {1'b0, c} <= DEPTH17);
    endfunction : in_range

    // a locked register in the run from line address a
    function automatic logic hits_lock(input logic [15:0]      a,
                                       input logic [15:0]      c,
                                       input logic [DEPTH-1:0] lk);
        logic [16:0] rel;
        logic        hit;
        rel = {1'b0, a} - BASE_LINE;
        hit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (lk[i] && 17'(i) >= rel && 17'(i) < rel + {1'b0, c}) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : hits_lock

    function automatic logic [15:0] word_at(input logic [MAXB-1:0][7:0] b,
                                            input logic [8:0] k);
        return {b[k], b[k + 9'h001]};
    endfunction : word_at

    function automatic logic is_hreg(input logic [11:0] a);
        return a >= `MBW_OFS_HREG && a < `MBW_OFS_HREG + 12'(DEPTH * 4);
    endfunction : is_hreg

    always_comb begin
        logic [7:0]  fc;
        logic [15:0] a1, c1, a2, c2, hr, ncrc;
        logic [7:0]  exc;
        logic [8:0]  k, nxt;
        logic [AW-1:0] hi;
        fc   = q.buf_b[1];
        a1   = word_at(q.buf_b, 9'h002);
        c1   = word_at(q.buf_b, 9'h004);
        a2   = word_at(q.buf_b, 9'h006);
        c2   = word_at(q.buf_b, 9'h008);
        exc  = mbw_pkg::EXC_NONE;
        k    = 9'h000;
        hr   = 16'h0000;
        ncrc = q.crc;
        nxt  = 9'h000;
        hi   = '0;
        d        = q;
        d.recalc = 1'b0;

        // apb: read data captured in the setup phase, writes at access
        if (psel && !penable) begin
            d.prdata = 32'h0000_0000;
            case (paddr)
                `MBW_OFS_CTRL:   d.prdata = {23'h0, q.en, q.my_addr};
                `MBW_OFS_DRIVE:  d.prdata = {29'h0, q.trip, q.uv, q.run};
                `MBW_OFS_LOCK:   d.prdata = 32'(q.lock);
                `MBW_OFS_STATUS: d.prdata = {7'h0, busy, q.last_exc,
                                             q.crc_cnt, q.ok_cnt};
                default: begin
                    if (is_hreg(paddr)) begin
                        hi = AW'((paddr - `MBW_OFS_HREG) >> 2);
                        d.prdata = {16'h0000, q.hreg[hi]};
                    end
                end
            endcase
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                `MBW_OFS_CTRL: begin
                    d.my_addr = pwdata[7:0];
                    d.en      = pwdata[`MBW_CTRL_EN_BIT];
                end
                `MBW_OFS_DRIVE: begin
                    d.run  = pwdata[`MBW_DRV_RUN_BIT];
                    d.uv   = pwdata[`MBW_DRV_UV_BIT];
                    d.trip = pwdata[`MBW_DRV_TRIP_BIT];
                end
                `MBW_OFS_LOCK: d.lock = pwdata[DEPTH-1:0];
                default: begin
                    if (is_hreg(paddr)) begin
                        hi = AW'((paddr - `MBW_OFS_HREG) >> 2);
                        d.hreg[hi] = pwdata[15:0];
                    end
                end
            endcase
        end

        // frame engine; its register writes follow the bus so they win
        case (q.st)
            mbw_pkg::S_IDLE: begin
                if (rx_valid) begin
                    d.buf_b[0] = rx_data;
                    d.len      = 9'h001;
                    d.ovf      = 1'b0;
                    d.crc      = crc_byte(`MBW_CRC_INIT, rx_data);
                    d.st       = rx_end ? mbw_pkg::S_CHECK : mbw_pkg::S_RX;
                end
            end
            mbw_pkg::S_RX: begin
                if (rx_valid) begin
                    if (q.len == 9'(MAXB)) begin
                        d.ovf = 1'b1;
                    end else begin
                        d.buf_b[q.len] = rx_data;
                        d.len          = q.len + 9'h001;
                        d.crc          = crc_byte(q.crc, rx_data);
                    end
                end
                if (rx_end) begin
                    d.st = mbw_pkg::S_CHECK;
                end
            end
            mbw_pkg::S_CHECK: begin
                d.st    = mbw_pkg::S_IDLE;
                d.bcast = (q.buf_b[0] == `MBW_BCAST_ADDR);
                d.idx   = 8'h00;
                if (q.ovf || q.len < `MBW_MIN_FRAME || q.crc != 16'h0000) begin
                    d.crc_cnt = q.crc_cnt + 8'h01;
                end else if (q.en && (q.buf_b[0] == q.my_addr ||
                                      q.buf_b[0] == `MBW_BCAST_ADDR)) begin
                    d.len = q.len - 9'h002;
                    case (fc)
                        `MBW_FC_WRITE_MULTI: begin
                            if (c1 == 16'h0 || c1 > `MBW_MAX_WCNT_10 ||
                                {8'h0, q.buf_b[6]} != (c1 << 1) ||
                                q.len != {1'b0, q.buf_b[6]} + 9'd9) begin
                                exc = mbw_pkg::EXC_DATA;
                            end else if (!in_range(a1, c1)) begin
                                exc = mbw_pkg::EXC_ADDR;
                            end else if (q.trip || (q.run &&
                                         hits_lock(a1, c1, q.lock))) begin
                                exc = mbw_pkg::EXC_DRIVE;
                            end
                            d.is17  = 1'b0;
                            d.wbase = AW'(a1 - BASE_LINE[15:0]);
                            d.wcnt  = c1[7:0];
                            d.dptr  = 9'd7;
                        end
                        `MBW_FC_READ_WRITE: begin
                            if (c1 == 16'h0 || c1 > `MBW_MAX_RCNT_17 ||
                                c2 == 16'h0 || c2 > `MBW_MAX_WCNT_17 ||
                                {8'h0, q.buf_b[10]} != (c2 << 1) ||
                                q.len != {1'b0, q.buf_b[10]} + 9'd13) begin
                                exc = mbw_pkg::EXC_DATA;
                            end else if (!in_range(a1, c1) ||
                                         !in_range(a2, c2)) begin
                                exc = mbw_pkg::EXC_ADDR;
                            end else if (q.trip || (q.run &&
                                         hits_lock(a2, c2, q.lock))) begin
                                exc = mbw_pkg::EXC_DRIVE;
                            end
                            d.is17  = 1'b1;
                            d.rbase = AW'(a1 - BASE_LINE[15:0]);
                            d.rcnt  = c1[7:0];
                            d.wbase = AW'(a2 - BASE_LINE[15:0]);
                            d.wcnt  = c2[7:0];
                            d.dptr  = 9'd11;
                        end
                        `MBW_FC_WRITE_SINGLE: begin
                            if (a1 != `MBW_RECALC_ADDR) begin
                                exc = mbw_pkg::EXC_FUNC;
                            end else if (q.len != 9'd8 ||
                                         c1 != `MBW_RECALC_VALUE) begin
                                exc = mbw_pkg::EXC_DATA;
                            end else if (q.run || q.uv || q.trip) begin
                                exc = mbw_pkg::EXC_DRIVE;
                            end
                        end
                        default: exc = mbw_pkg::EXC_FUNC;
                    endcase
                    if (exc != mbw_pkg::EXC_NONE) begin
                        d.buf_b[1] = fc | `MBW_EXC_FLAG;
                        d.buf_b[2] = exc;
                        d.len      = 9'h003;
                        d.last_exc = exc;
                        d.st = d.bcast ? mbw_pkg::S_IDLE : mbw_pkg::S_TX;
                    end else if (fc == `MBW_FC_WRITE_SINGLE) begin
                        d.recalc = 1'b1;
                        d.len    = 9'h006;
                        d.ok_cnt = q.ok_cnt + 8'h01;
                        d.st = d.bcast ? mbw_pkg::S_IDLE : mbw_pkg::S_TX;
                    end else begin
                        d.st = mbw_pkg::S_WR;
                    end
                    d.txi = 9'h000;
                    d.txd = q.buf_b[0];
                    d.crc = `MBW_CRC_INIT;
                end
            end
            mbw_pkg::S_WR: begin
                // one register per cycle, data high byte first
                k  = q.dptr + {q.idx, 1'b0};
                hi = q.wbase + AW'(q.idx);
                d.hreg[hi] = word_at(q.buf_b, k);
                d.idx      = q.idx + 8'h01;
                if (q.idx == q.wcnt - 8'h01) begin
                    d.idx = 8'h00;
                    if (q.is17) begin
                        // read runs only after every write landed
                        d.buf_b[2] = {q.rcnt[6:0], 1'b0};
                        d.len      = 9'h003 + {q.rcnt, 1'b0};
                        d.st       = mbw_pkg::S_RD;
                    end else begin
                        d.len    = 9'h006;
                        d.ok_cnt = q.ok_cnt + 8'h01;
                        d.st = q.bcast ? mbw_pkg::S_IDLE : mbw_pkg::S_TX;
                    end
                end
            end
            mbw_pkg::S_RD: begin
                // write data is consumed, so the reply may overwrite it
                k  = 9'h003 + {q.idx, 1'b0};
                hi = q.rbase + AW'(q.idx);
                hr = q.hreg[hi];
                d.buf_b[k]          = hr[15:8];
                d.buf_b[k + 9'h001] = hr[7:0];
                d.idx               = q.idx + 8'h01;
                if (q.idx == q.rcnt - 8'h01) begin
                    d.ok_cnt = q.ok_cnt + 8'h01;
                    d.st = q.bcast ? mbw_pkg::S_IDLE : mbw_pkg::S_TX;
                end
            end
            mbw_pkg::S_TX: begin
                if (tx_ready) begin
                    if (q.txi < q.len) begin
                        ncrc = crc_byte(q.crc, q.txd);
                    end
                    nxt   = q.txi + 9'h001;
                    d.crc = ncrc;
                    d.txi = nxt;
                    if (nxt < q.len) begin
                        d.txd = q.buf_b[nxt];
                    end else if (nxt == q.len) begin
                        d.txd = ncrc[7:0];
                    end else if (nxt == q.len + 9'h001) begin
                        d.txd = ncrc[15:8];
                    end else begin
                        d.st = mbw_pkg::S_IDLE;
                    end
                end
            end
            default: d.st = mbw_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q         <= '0;
            q.crc     <= `MBW_CRC_INIT;
            q.my_addr <= `MBW_RST_SLAVE_ADDR;
            q.en      <= `MBW_RST_EN;
        end else begin
            q <= d;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     !(paddr == `MBW_OFS_CTRL || paddr == `MBW_OFS_DRIVE ||
                       paddr == `MBW_OFS_LOCK || paddr == `MBW_OFS_STATUS ||
                       is_hreg(paddr));

    assign prdata       = q.prdata;
    assign tx_valid     = (q.st == mbw_pkg::S_TX);
    assign tx_data      = q.txd;
    assign recalc_pulse = q.recalc;
    assign busy         = (q.st != mbw_pkg::S_IDLE) && (q.st != mbw_pkg::S_RX);

endmodule : mbw_top

// ---- sim/mbw_master_model.sv ----
// serial master behind the framer: queries out, replies in
// assumes the bench loads qb and waits for busy to fall between frames
module mbw_master_model (
    // clock
    input wire logic       core_clk,
    // query bytes towards the block
    output logic           rx_valid,
    output logic     [7:0] rx_data,
    output logic           rx_end,
    // reply bytes from the block
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    output logic           tx_ready,
    input wire logic       busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] qb[0:39];
    logic [7:0] got[$];
    logic       slow = 1'h0;

    initial begin
        rx_valid = 1'h0;
        rx_data  = 8'h00;
        rx_end   = 1'h0;
        tx_ready = 1'h1;
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction : crc_step

    task automatic send(input int n, input logic bad);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) c = crc_step(c, qb[i]);
        if (bad) c = ~c;
        qb[n] = c[7:0];
        qb[n+1] = c[15:8];
        got.delete();
        for (int i = 0; i < n + 2; i++) begin
            @(posedge core_clk);
            rx_valid <= 1'h1;
            rx_data <= qb[i];
        end
        @(posedge core_clk);
        rx_valid <= 1'h0;
        rx_data <= ~qb[n+1];
        rx_end <= 1'h1;
        @(posedge core_clk);
        rx_end <= 1'h0;
    endtask : send

    // a slow master accepts only every other cycle
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'h1;
    end
endmodule : mbw_master_model

// ---- sim/mbw_top_monitor.sv ----
// checker of the frame handler, on top ports only
// assumes one clock domain and the framer byte links
module mbw_top_monitor (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // received bytes
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       rx_end,
    // transmitted bytes
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    // drive side
    input wire logic       recalc_pulse,
    input wire logic       busy
);
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] fc;
        logic [7:0] rfc;
        logic [8:0] rxn;
        logic [8:0] txn;
    } mbw_mon_t;

    mbw_mon_t s_q;
    mbw_mon_t s_d;

    // remember query address and function, count reply bytes
    always_comb begin
        s_d = s_q;
        if (rx_valid && !busy) begin
            if (s_q.rxn == 9'h000) s_d.addr = rx_data;
            if (s_q.rxn == 9'h001) s_d.fc = rx_data;
            s_d.rxn = s_q.rxn + 9'h001;
        end
        if (rx_end) s_d.rxn = 9'h000;
        if (!busy) s_d.txn = 9'h000;
        else if (tx_valid && tx_ready) begin
            if (s_q.txn == 9'h001) s_d.rfc = tx_data;
            s_d.txn = s_q.txn + 9'h001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) s_q <= '0;
        else s_q <= s_d;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_bcast_silent: assert property (
        busy && s_q.addr == 8'h00 |-> !tx_valid)
        else $error("broadcast answered");
    a_tx_in_busy: assert property (tx_valid |-> busy)
        else $error("tx while idle");
    a_reply_addr: assert property (
        $rose(tx_valid) |-> tx_data == s_q.addr)
        else $error("bad reply address");
    a_func_echo: assert property (
        tx_valid && s_q.txn == 9'h001 |->
        tx_data == s_q.fc || tx_data == (s_q.fc | 8'h80))
        else $error("bad reply function");
    a_exc_code: assert property (
        tx_valid && s_q.txn == 9'h002 && s_q.rfc[7]
        |-> tx_data inside {8'h01, 8'h02, 8'h03, 8'h22})
        else $error("bad exception code");
    a_exc_len: assert property (
        $fell(tx_valid) && s_q.rfc[7] |-> s_q.txn == 9'h005)
        else $error("bad exception length");
    a_wr10_len: assert property (
        $fell(tx_valid) && s_q.rfc == 8'h10 |-> s_q.txn == 9'h008)
        else $error("bad write reply length");
    a_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte not held");
    a_recalc_cause: assert property (recalc_pulse |-> s_q.fc == 8'h06)
        else $error("stray recalculation");
endmodule : mbw_top_monitor

bind mbw_top mbw_top_monitor i_mbw_top_monitor (
    .core_clk(core_clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .recalc_pulse(recalc_pulse),
    .busy(busy)
);

// ---- sim/tb_mbw_top.sv ----
// self-checking bench of the frame handler
// assumes default parameters and the master model beside it
module tb_mbw_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        rx_valid, rx_end, tx_valid, tx_ready, recalc_pulse, busy;
    logic [7:0]  rx_data, tx_data;
    logic        rc_seen;
    int          failures, checks, cyc;

    mbw_top i_mbw_top (.core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .recalc_pulse(recalc_pulse), .busy(busy));
    mbw_master_model i_mst (.core_clk(core_clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_end(rx_end), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy));

    always #5 core_clk = ~core_clk;

    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    always @(posedge core_clk) begin
        cyc++;
        if (recalc_pulse === 1'h1) rc_seen <= 1'h1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) @(posedge core_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rd

    // query q of n bytes, expected reply e of m bytes, both without crc
    task automatic frame(input logic [319:0] q, input int n,
                         input logic [319:0] e, input int m, input logic bad);
        logic [15:0] c;
        int          k;
        for (int i = 0; i < n; i++) i_mst.qb[i] = q[8*(n-1-i) +: 8];
        i_mst.send(n, bad);
        k = 0;
        while (busy !== 1'h1 && k < 8) begin
            @(posedge core_clk);
            k++;
        end
        while (busy !== 1'h0) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        c = 16'hFFFF;
        for (int i = 0; i < m; i++) c = i_mst.crc_step(c, e[8*(m-1-i) +: 8]);
        check(32'(i_mst.got.size()), (m == 0) ? 32'h0 : 32'(m + 2));
        for (int i = 0; i < m; i++)
            check({24'h0, i_mst.got[i]}, {24'h0, e[8*(m-1-i) +: 8]});
        if (m > 0) begin
            check({24'h0, i_mst.got[m]}, {24'h0, c[7:0]});
            check({24'h0, i_mst.got[m+1]}, {24'h0, c[15:8]});
        end
    endtask : frame

    task automatic t_regs;
        rd(12'h000, 32'h0000_0101, 1'h0);
        rd(12'h0F0, 32'h0, 1'h1);
    endtask : t_regs

    task automatic t_wr10;
        logic [319:0] q;
        q = {8'h01, 8'h10, 16'h0002, 16'h0002, 8'h04, 16'hABCD, 16'h1234};
        frame(q, 11, '0, 0, 1'h1);
        rd(12'h108, 32'h0, 1'h0);
        i_mst.slow = 1'h1;
        frame(q, 11, {8'h01, 8'h10, 16'h0002, 16'h0002}, 6, 1'h0);
        i_mst.slow = 1'h0;
        rd(12'h108, 32'h0000_ABCD, 1'h0);
        rd(12'h10C, 32'h0000_1234, 1'h0);
    endtask : t_wr10

    task automatic t_rw17;
        frame({8'h01, 8'h17, 16'h0002, 16'h0004, 16'h0005, 16'h0001, 8'h02,
               16'h5A5A}, 13, {8'h01, 8'h17, 8'h08, 16'hABCD, 16'h1234,
               16'h0000, 16'h5A5A}, 11, 1'h0);
        rd(12'h114, 32'h0000_5A5A, 1'h0);
    endtask : t_rw17

    task automatic t_exc;
        frame({8'h01, 8'h03, 16'h0000, 16'h0001}, 6,
              {8'h01, 8'h83, 8'h01}, 3, 1'h0);
        frame({8'h01, 8'h10, 16'h000F, 16'h0002, 8'h04, 32'h1111_2222}, 11,
              {8'h01, 8'h90, 8'h02}, 3, 1'h0);
        frame({8'h01, 8'h10, 16'h0000, 16'h0001, 8'h04, 16'h1111}, 9,
              {8'h01, 8'h90, 8'h03}, 3, 1'h0);
        frame({8'h01, 8'h17, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 8'h02,
               16'h1111}, 13, {8'h01, 8'h97, 8'h03}, 3, 1'h0);
    endtask : t_exc

    task automatic t_drv;
        logic [319:0] rc;
        rc = {8'h01, 8'h06, 16'h08FF, 16'h0000};
        wr(12'h004, 32'h1);
        wr(12'h008, 32'h1);
        frame({8'h01, 8'h10, 16'h0000, 16'h0001, 8'h02, 16'h4444}, 9,
              {8'h01, 8'h90, 8'h22}, 3, 1'h0);
        frame(rc, 6, {8'h01, 8'h86, 8'h22}, 3, 1'h0);
        wr(12'h004, 32'h2);
        frame(rc, 6, {8'h01, 8'h86, 8'h22}, 3, 1'h0);
        wr(12'h004, 32'h4);
        frame({8'h01, 8'h10, 16'h0001, 16'h0001, 8'h02, 16'h4444}, 9,
              {8'h01, 8'h90, 8'h22}, 3, 1'h0);
        wr(12'h004, 32'h0);
        rc_seen = 1'h0;
        frame(rc, 6, rc, 6, 1'h0);
        check({31'h0, rc_seen}, 32'h1);
        frame({8'h01, 8'h06, 16'h08FF, 16'h0001}, 6,
              {8'h01, 8'h86, 8'h03}, 3, 1'h0);
    endtask : t_drv

    task automatic t_bcast;
        frame({8'h00, 8'h10, 16'h0006, 16'h0001, 8'h02, 16'h7777}, 9,
              '0, 0, 1'h0);
        rd(12'h118, 32'h0000_7777, 1'h0);
        frame({8'h02, 8'h10, 16'h0006, 16'h0001, 8'h02, 16'h8888}, 9,
              '0, 0, 1'h0);
        rd(12'h118, 32'h0000_7777, 1'h0);
    endtask : t_bcast

    initial begin
        core_clk = 1'h0;
        resetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rc_seen = 1'h0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        t_regs();
        t_wr10();
        t_rw17();
        t_exc();
        t_drv();
        t_bcast();
        test_done();
    end
endmodule : tb_mbw_top
